// file: verilog/lib_consts.vh
// Purpose: shared constants of the host-to-expansion bus bridge
// Assumes: 10 MHz MCLK
// Notes: offsets are byte addresses on the register port
`ifndef LIB_CONSTS_VH
`define LIB_CONSTS_VH

// register port offsets
`define LIB_REG_CTRL 8'h00
`define LIB_REG_IRQEN 8'h04
`define LIB_REG_STAT 8'h08

// control register: [0] port a enable, [1] port b enable, [7:4] port a sel, [11:8] port b sel
`define LIB_CTRL_W 12
`define LIB_CTRL_RST 12'h983
`define LIB_IRQEN_RST 16'h0000
`define LIB_IRQ_OK 16'h9ef8

// claimed and forwarded ranges
`define LIB_OWN_BLK 10'h032
`define LIB_MEM_LO 20'ha0000
`define LIB_MEM_HI 20'hb7fff

// selectable serial port bases, index 0..9
`define LIB_COM_B0 16'h0200
`define LIB_COM_B1 16'h0208
`define LIB_COM_B2 16'h0220
`define LIB_COM_B3 16'h0228
`define LIB_COM_B4 16'h0238
`define LIB_COM_B5 16'h02e8
`define LIB_COM_B6 16'h0338
`define LIB_COM_B7 16'h03e8
`define LIB_COM_B8 16'h03f8
`define LIB_COM_B9 16'h02f8

// host link nibbles
`define LIB_NIB_START 4'h0
`define LIB_NIB_SYNC_WAIT 4'h6
`define LIB_NIB_SYNC_OK 4'h0
`define LIB_NIB_TAR 4'hf

// expansion bus timing
`define LIB_CLK_MHZ 10
`define LIB_CMD8_NS 500
`define LIB_CMD16_NS 300
`define LIB_RDY_MAX_NS 2500
`define LIB_CMD8_CYC ((`LIB_CMD8_NS * `LIB_CLK_MHZ + 999) / 1000)
`define LIB_CMD16_CYC ((`LIB_CMD16_NS * `LIB_CLK_MHZ + 999) / 1000)
`define LIB_RDY_MAX_CYC ((`LIB_RDY_MAX_NS * `LIB_CLK_MHZ) / 1000)

`endif

// file: verilog/lib_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock, synchronous active-low reset
// Notes: first stage read only by second stage
`timescale 1ns/100ps
module lib_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire rstn,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_q;

	always @(posedge clk)
	begin
		if (!rstn)
		begin
			meta_q <= {W{1'b0}};
			q <= {W{1'b0}};
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // lib_sync

// file: verilog/lib_iodec.v
// Purpose: io address decode for claimed and withheld ranges
// Assumes: 16-bit io address
// Notes: purely combinational
`timescale 1ns/100ps
`include "lib_consts.vh"
module lib_iodec (
	input wire [15:0] addr,
	input wire [1:0] com_en,
	input wire [3:0] com_a_sel,
	input wire [3:0] com_b_sel,
	output wire own,
	output wire com_hit
);
	// valid flag and base of a selector
	function [16:0] base_of;
		input [3:0] sel;
		begin
			case (sel)
				4'h0: base_of = {1'b1, `LIB_COM_B0};
				4'h1: base_of = {1'b1, `LIB_COM_B1};
				4'h2: base_of = {1'b1, `LIB_COM_B2};
				4'h3: base_of = {1'b1, `LIB_COM_B3};
				4'h4: base_of = {1'b1, `LIB_COM_B4};
				4'h5: base_of = {1'b1, `LIB_COM_B5};
				4'h6: base_of = {1'b1, `LIB_COM_B6};
				4'h7: base_of = {1'b1, `LIB_COM_B7};
				4'h8: base_of = {1'b1, `LIB_COM_B8};
				4'h9: base_of = {1'b1, `LIB_COM_B9};
				default: base_of = 17'h00000;
			endcase
		end
	endfunction

	wire [16:0] a_base;
	wire [16:0] b_base;
	wire a_hit;
	wire b_hit;

	assign a_base = base_of(com_a_sel);
	assign b_base = base_of(com_b_sel);
	assign a_hit = com_en[0] && a_base[16] && (addr[15:3] == a_base[15:3]);
	assign b_hit = com_en[1] && b_base[16] && (addr[15:3] == b_base[15:3]);
	assign com_hit = a_hit || b_hit;
	assign own = (addr[15:6] == `LIB_OWN_BLK);
endmodule // lib_iodec

// file: verilog/lib_bridge.v
// Purpose: host nibble-bus target bridged to an expansion bus master
// Assumes: host link clocked by MCLK; expansion pins asynchronous
// Notes: one host cycle at a time; host held by wait sync until done
`timescale 1ns/100ps
`include "lib_consts.vh"
// Function
// - bridge alone masters the expansion bus
// - bus-master request line unconnected, ignored
// - refresh output held inactive high
// - no dma: acks high, requests ignored, tc low
// - run 8-bit and 16-bit io cycles
// - forward io only when nobody else claims
// - own block c80-cbf, never forwarded
// - serial ports default enabled at 3f8, 2f8
// - serial base chosen from fixed table
// - enabled serial port withholds its 8 bytes
// - forward memory only a0000 to b7fff
// - pass only irq 3-7, 9-12, 15
// - per-line irq enable, cleared at reset
module lib_bridge (
	input wire MCLK,
	input wire RSTN,
	input wire [7:0] REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [31:0] REG_RDATA,
	input wire LFRAME_N,
	input wire [3:0] LAD_I,
	output reg [3:0] LAD_O,
	output reg LAD_OE_N,
	input wire OTHER_CLAIM,
	output reg [19:0] SA,
	output reg SBHE_N,
	output reg BALE,
	output reg IOR_N,
	output reg IOW_N,
	output reg MEMR_N,
	output reg MEMW_N,
	input wire [15:0] SD_I,
	output reg [15:0] SD_O,
	output reg SD_OE_N,
	input wire IOCS16_N,
	input wire IOCHRDY,
	input wire [15:0] ISA_IRQ,
	output reg [15:0] HOST_IRQ,
	output reg REFRESH_N,
	output reg [6:0] DACK_N,
	output reg TC
);
	localparam integer CMD8_CYC = `LIB_CMD8_CYC;
	localparam integer CMD16_CYC = `LIB_CMD16_CYC;
	localparam integer RDY_MAX_CYC = `LIB_RDY_MAX_CYC;

	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_TYPE = 4'h1;
	localparam [3:0] S_ADDR = 4'h2;
	localparam [3:0] S_WD0 = 4'h3;
	localparam [3:0] S_WD1 = 4'h4;
	localparam [3:0] S_TAR1 = 4'h5;
	localparam [3:0] S_TAR2 = 4'h6;
	localparam [3:0] S_SYNC = 4'h7;
	localparam [3:0] S_RD0 = 4'h8;
	localparam [3:0] S_RD1 = 4'h9;
	localparam [3:0] S_TB1 = 4'ha;
	localparam [3:0] S_TB2 = 4'hb;

	localparam [1:0] I_IDLE = 2'h0;
	localparam [1:0] I_ADR = 2'h1;
	localparam [1:0] I_CMD = 2'h2;
	localparam [1:0] I_HOLD = 2'h3;

	reg [3:0] st_q;
	reg [2:0] nib_q;
	reg [31:0] addr_q;
	reg is_mem_q;
	reg is_wr_q;
	reg own_q;
	reg [7:0] wd_q;
	reg [7:0] rd_q;
	reg isa_go_q;
	reg isa_done_q;
	reg [1:0] ist_q;
	reg [7:0] cnt_q;
	reg cs16_q;
	reg last16_q;
	reg timeout_q;
	reg [`LIB_CTRL_W-1:0] ctrl_q;
	reg [15:0] irqen_q;

	wire [33:0] pin_s;
	wire cs16_s;
	wire rdy_s;
	wire [15:0] irq_s;
	wire [15:0] sd_s;
	wire dec_own;
	wire dec_com;
	wire mem_win;
	wire fwd;
	wire [7:0] min_cyc;
	wire cmd_end;

	lib_sync #(
		.W(34)
	) u_sync (
		.clk(MCLK),
		.rstn(RSTN),
		.d({IOCS16_N, IOCHRDY, ISA_IRQ, SD_I}),
		.q(pin_s)
	);

	assign cs16_s = ~pin_s[33];
	assign rdy_s = pin_s[32];
	assign irq_s = pin_s[31:16];
	assign sd_s = pin_s[15:0];

	lib_iodec u_iodec (
		.addr(addr_q[15:0]),
		.com_en(ctrl_q[1:0]),
		.com_a_sel(ctrl_q[7:4]),
		.com_b_sel(ctrl_q[11:8]),
		.own(dec_own),
		.com_hit(dec_com)
	);

	assign mem_win = (addr_q[31:20] == 12'h000) && (addr_q[19:0] >= `LIB_MEM_LO)
		&& (addr_q[19:0] <= `LIB_MEM_HI);
	assign fwd = is_mem_q ? (mem_win && !OTHER_CLAIM)
		: (!dec_own && !dec_com && !OTHER_CLAIM);
	assign min_cyc = (cs16_q && !is_mem_q) ? CMD16_CYC[7:0] : CMD8_CYC[7:0];
	assign cmd_end = (cnt_q >= (min_cyc - 8'h01))
		&& (rdy_s || (cnt_q >= RDY_MAX_CYC[7:0]));

	// register port
	always @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			ctrl_q <= `LIB_CTRL_RST;
			irqen_q <= `LIB_IRQEN_RST;
			REG_RDATA <= 32'h00000000;
		end
		else
		begin
			if (REG_WR && (REG_ADDR == `LIB_REG_CTRL))
				ctrl_q <= REG_WDATA[`LIB_CTRL_W-1:0];
			if (REG_WR && (REG_ADDR == `LIB_REG_IRQEN))
				irqen_q <= REG_WDATA[15:0] & `LIB_IRQ_OK;
			if (REG_RD)
			begin
				case (REG_ADDR)
					`LIB_REG_CTRL: REG_RDATA <= {20'h00000, ctrl_q};
					`LIB_REG_IRQEN: REG_RDATA <= {16'h0000, irqen_q};
					`LIB_REG_STAT: REG_RDATA <= {irq_s, 12'h000, timeout_q, last16_q,
						(ist_q != I_IDLE), (st_q != S_IDLE)};
					default: REG_RDATA <= 32'h00000000;
				endcase
			end
			else
				REG_RDATA <= 32'h00000000;
		end
	end

	// interrupt routing and fixed bus lines
	always @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			HOST_IRQ <= 16'h0000;
			REFRESH_N <= 1'b1;
			DACK_N <= 7'h7f;
			TC <= 1'b0;
		end
		else
		begin
			HOST_IRQ <= irq_s & irqen_q & `LIB_IRQ_OK;
			REFRESH_N <= 1'b1;
			DACK_N <= 7'h7f;
			TC <= 1'b0;
		end
	end

	// host link target
	always @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			st_q <= S_IDLE;
			nib_q <= 3'h0;
			addr_q <= 32'h00000000;
			is_mem_q <= 1'b0;
			is_wr_q <= 1'b0;
			own_q <= 1'b0;
			wd_q <= 8'h00;
			isa_go_q <= 1'b0;
			LAD_O <= `LIB_NIB_TAR;
			LAD_OE_N <= 1'b1;
		end
		else
		begin
			isa_go_q <= 1'b0;
			if (!LFRAME_N)
			begin
				LAD_OE_N <= 1'b1;
				st_q <= (LAD_I == `LIB_NIB_START) ? S_TYPE : S_IDLE;
			end
			else
			begin
				case (st_q)
					S_IDLE: st_q <= S_IDLE;
					S_TYPE:
					begin
						addr_q <= 32'h00000000;
						is_mem_q <= LAD_I[2];
						is_wr_q <= LAD_I[1];
						nib_q <= LAD_I[2] ? 3'h7 : 3'h3;
						st_q <= (LAD_I[3] == 1'b0) ? S_ADDR : S_IDLE;
					end
					S_ADDR:
					begin
						addr_q <= {addr_q[27:0], LAD_I};
						nib_q <= nib_q - 3'h1;
						if (nib_q == 3'h0)
							st_q <= is_wr_q ? S_WD0 : S_TAR1;
					end
					S_WD0:
					begin
						wd_q[3:0] <= LAD_I;
						st_q <= S_WD1;
					end
					S_WD1:
					begin
						wd_q[7:4] <= LAD_I;
						st_q <= S_TAR1;
					end
					S_TAR1: st_q <= S_TAR2;
					S_TAR2:
					begin
						own_q <= !is_mem_q && dec_own;
						if (fwd || (!is_mem_q && dec_own))
						begin
							LAD_O <= `LIB_NIB_SYNC_WAIT;
							LAD_OE_N <= 1'b0;
							isa_go_q <= fwd;
							st_q <= S_SYNC;
						end
						else
							st_q <= S_IDLE;
					end
					S_SYNC:
					begin
						if (own_q || isa_done_q)
						begin
							LAD_O <= `LIB_NIB_SYNC_OK;
							st_q <= is_wr_q ? S_TB1 : S_RD0;
						end
					end
					S_RD0:
					begin
						LAD_O <= own_q ? 4'hf : rd_q[3:0];
						st_q <= S_RD1;
					end
					S_RD1:
					begin
						LAD_O <= own_q ? 4'hf : rd_q[7:4];
						st_q <= S_TB1;
					end
					S_TB1:
					begin
						LAD_O <= `LIB_NIB_TAR;
						st_q <= S_TB2;
					end
					S_TB2:
					begin
						LAD_OE_N <= 1'b1;
						st_q <= S_IDLE;
					end
					default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	// expansion bus master
	always @(posedge MCLK)
	begin
		if (!RSTN)
		begin
			ist_q <= I_IDLE;
			cnt_q <= 8'h00;
			cs16_q <= 1'b0;
			last16_q <= 1'b0;
			timeout_q <= 1'b0;
			rd_q <= 8'h00;
			isa_done_q <= 1'b0;
			SA <= 20'h00000;
			SBHE_N <= 1'b1;
			BALE <= 1'b0;
			IOR_N <= 1'b1;
			IOW_N <= 1'b1;
			MEMR_N <= 1'b1;
			MEMW_N <= 1'b1;
			SD_O <= 16'h0000;
			SD_OE_N <= 1'b1;
		end
		else
		begin
			isa_done_q <= 1'b0;
			case (ist_q)
				I_IDLE:
				begin
					if (isa_go_q)
					begin
						SA <= addr_q[19:0];
						SBHE_N <= ~addr_q[0];
						BALE <= 1'b1;
						cs16_q <= 1'b0;
						ist_q <= I_ADR;
					end
				end
				I_ADR:
				begin
					BALE <= 1'b0;
					cnt_q <= 8'h00;
					IOR_N <= ~(!is_mem_q && !is_wr_q);
					IOW_N <= ~(!is_mem_q && is_wr_q);
					MEMR_N <= ~(is_mem_q && !is_wr_q);
					MEMW_N <= ~(is_mem_q && is_wr_q);
					SD_O <= {wd_q, wd_q};
					SD_OE_N <= ~is_wr_q;
					ist_q <= I_CMD;
				end
				I_CMD:
				begin
					cnt_q <= cnt_q + 8'h01;
					if (cs16_s && !is_mem_q)
						cs16_q <= 1'b1;
					if (cmd_end)
					begin
						rd_q <= (cs16_q && addr_q[0]) ? sd_s[15:8] : sd_s[7:0];
						last16_q <= cs16_q;
						timeout_q <= !rdy_s;
						IOR_N <= 1'b1;
						IOW_N <= 1'b1;
						MEMR_N <= 1'b1;
						MEMW_N <= 1'b1;
						ist_q <= I_HOLD;
					end
				end
				I_HOLD:
				begin
					SD_OE_N <= 1'b1;
					SBHE_N <= 1'b1;
					isa_done_q <= 1'b1;
					ist_q <= I_IDLE;
				end
				default: ist_q <= I_IDLE;
			endcase
		end
	end
endmodule // lib_bridge

// file: tb/lib_bridge_checker.sv
// Purpose: port checks for the bus bridge
// Assumes: MCLK domain only
// Notes: bound under the design top
`timescale 1ns/100ps
module lib_bridge_checker (
	input wire MCLK,
	input wire RSTN,
	input wire [19:0] SA,
	input wire SBHE_N,
	input wire BALE,
	input wire IOR_N,
	input wire IOW_N,
	input wire MEMR_N,
	input wire MEMW_N,
	input wire LAD_OE_N,
	input wire [15:0] HOST_IRQ,
	input wire REFRESH_N,
	input wire [6:0] DACK_N,
	input wire TC
);
	wire cmd = !(IOR_N && IOW_N && MEMR_N && MEMW_N);
	wire io = !IOR_N || !IOW_N;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	sequence s_cmd;
		!BALE && cmd;
	endsequence
	sequence s_hold;
		cmd [*3];
	endsequence
	a_refresh_high: assert property (REFRESH_N)
		else $error("refresh active");
	a_dma_idle: assert property (DACK_N == 7'h7f && !TC)
		else $error("dma pins active");
	a_irq_supported: assert property ((HOST_IRQ & ~16'h9ef8) == 16'h0000)
		else $error("unsupported irq passed");
	a_one_strobe: assert property ($onehot0(~{IOR_N, IOW_N, MEMR_N, MEMW_N}))
		else $error("two strobes at once");
	a_bale_cmd: assert property ($rose(BALE) |=> s_cmd)
		else $error("no strobe after latch");
	a_strobe_min: assert property ($rose(cmd) |-> s_hold)
		else $error("strobe too short");
	a_mem_window: assert property (!MEMR_N || !MEMW_N |-> SA >= 20'ha0000 && SA <= 20'hb7fff)
		else $error("memory outside window");
	a_own_block: assert property ($rose(cmd) && io |-> SA[15:6] != 10'h032)
		else $error("own block forwarded");
	a_byte_high: assert property (cmd |-> SBHE_N == !SA[0])
		else $error("high byte enable wrong");
	a_host_held: assert property (cmd |-> !LAD_OE_N)
		else $error("host not held");
endmodule // lib_bridge_checker
bind lib_bridge lib_bridge_checker i_chk (
	.MCLK(MCLK),
	.RSTN(RSTN),
	.SA(SA),
	.SBHE_N(SBHE_N),
	.BALE(BALE),
	.IOR_N(IOR_N),
	.IOW_N(IOW_N),
	.MEMR_N(MEMR_N),
	.MEMW_N(MEMW_N),
	.LAD_OE_N(LAD_OE_N),
	.HOST_IRQ(HOST_IRQ),
	.REFRESH_N(REFRESH_N),
	.DACK_N(DACK_N),
	.TC(TC)
);

// file: tb/lib_isa_mdl.sv
// Purpose: expansion module on the far bus
// Assumes: read data {~sa, sa} low byte
// Notes: stall holds ready low
`timescale 1ns/100ps
module lib_isa_mdl (
	input wire clk,
	input wire [19:0] sa,
	input wire ior_n,
	input wire iow_n,
	input wire memr_n,
	input wire memw_n,
	input wire [15:0] sd,
	input wire wide,
	input wire [4:0] stall,
	output wire [15:0] sd_drv,
	output wire iocs16_n,
	output wire iochrdy,
	output reg [7:0] wdat
);
	reg [4:0] cnt_q;
	reg [7:0] pat_q;
	wire cmd = !(ior_n && iow_n && memr_n && memw_n);
	// drives {~sa, sa} while read strobe low, a running {pat, ~pat} pattern otherwise
	assign sd_drv = (!ior_n || !memr_n) ? {~sa[7:0], sa[7:0]} : {pat_q, ~pat_q};
	assign iocs16_n = !wide;
	assign iochrdy = !cmd || cnt_q >= stall;
	// never requests the bus, no master pin
	initial cnt_q = 5'h00;
	initial pat_q = 8'h00;
	initial wdat = 8'h00;
	always @(posedge clk)
	begin
		pat_q <= pat_q + 8'h01;
		cnt_q <= cmd ? cnt_q + {4'h0, cnt_q != 5'h1f} : 5'h00;
		if (!iow_n || !memw_n)
			wdat <= sd[7:0];
	end
endmodule // lib_isa_mdl

// file: tb/lib_bridge_tb_top.sv
// Purpose: self-checking bench for the bridge
// Assumes: 10 MHz MCLK
// Notes: host cycles driven nibble by nibble
`timescale 1ns/100ps
module lib_bridge_tb_top;
	reg MCLK, rstn, rwr, rrd, lfr_n, oc, wide;
	reg [7:0] ra;
	reg [31:0] rwd, rd;
	reg [3:0] lad;
	reg [15:0] irq;
	reg [4:0] stall;
	integer failures, checked;
	wire [31:0] REG_RDATA;
	wire [3:0] LAD_O;
	wire [19:0] SA;
	wire [15:0] SD_O, HOST_IRQ, m_sd;
	wire [6:0] DACK_N;
	wire [7:0] wdat;
	wire LAD_OE_N, SD_OE_N, BALE, IOR_N, IOW_N, MEMR_N, MEMW_N, cs16_n, rdy, REFRESH_N, TC;
	wire [3:0] lad_w = LAD_OE_N ? lad : LAD_O;
	wire [15:0] sd_w = SD_OE_N ? m_sd : SD_O;
	lib_bridge i_lib_bridge (.MCLK(MCLK), .RSTN(rstn), .REG_ADDR(ra), .REG_WDATA(rwd),
		.REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(REG_RDATA), .LFRAME_N(lfr_n), .LAD_I(lad_w),
		.LAD_O(LAD_O), .LAD_OE_N(LAD_OE_N), .OTHER_CLAIM(oc), .SA(SA), .SBHE_N(), .BALE(BALE),
		.IOR_N(IOR_N), .IOW_N(IOW_N), .MEMR_N(MEMR_N), .MEMW_N(MEMW_N), .SD_I(sd_w),
		.SD_O(SD_O), .SD_OE_N(SD_OE_N), .IOCS16_N(cs16_n), .IOCHRDY(rdy), .ISA_IRQ(irq),
		.HOST_IRQ(HOST_IRQ), .REFRESH_N(REFRESH_N), .DACK_N(DACK_N), .TC(TC));
	lib_isa_mdl i_lib_isa_mdl (.clk(MCLK), .sa(SA), .ior_n(IOR_N), .iow_n(IOW_N),
		.memr_n(MEMR_N), .memw_n(MEMW_N), .sd(sd_w), .wide(wide), .stall(stall),
		.sd_drv(m_sd), .iocs16_n(cs16_n), .iochrdy(rdy), .wdat(wdat));
	task end_of_test;
		begin
			if (failures == 0 && checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			checked = checked + 1;
			if (s !== e)
			begin
				failures = failures + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task reg_wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge MCLK);
			ra <= a;
			rwd <= d;
			rwr <= 1'b1;
			@(posedge MCLK);
			rwr <= 1'b0;
		end
	endtask
	task reg_rd(input [7:0] a, input [31:0] e);
		begin
			@(posedge MCLK);
			ra <= a;
			rrd <= 1'b1;
			@(posedge MCLK);
			rrd <= 1'b0;
			#1 chk(REG_RDATA, e);
		end
	endtask
	// one host cycle; e says whether the bridge must answer
	task lpc(input [3:0] t, input [31:0] a, input [7:0] wd, input e, input [7:0] er);
		integer i;
		reg ok;
		reg [7:0] d;
		begin
			ok = 1'b0;
			d = 8'h00;
			@(posedge MCLK);
			lfr_n <= 1'b0;
			lad <= 4'h0;
			@(posedge MCLK);
			lfr_n <= 1'b1;
			lad <= t;
			for (i = t[2] ? 7 : 3; i >= 0; i = i - 1)
				@(posedge MCLK) lad <= a[i*4 +: 4];
			for (i = 0; i < 2 && t[1]; i = i + 1)
				@(posedge MCLK) lad <= wd[i*4 +: 4];
			@(posedge MCLK) lad <= 4'hf;
			@(posedge MCLK);
			for (i = 0; i < 60 && !ok; i = i + 1)
				@(posedge MCLK) #1 ok = LAD_OE_N === 1'b0 && LAD_O === 4'h0;
			for (i = 0; i < 2 && ok && !t[1]; i = i + 1)
				@(posedge MCLK) #1 d[i*4 +: 4] = LAD_O;
			chk(ok, e);
			if (ok !== e && e)
				end_of_test;
			if (ok)
			begin
				chk(d, er);
				@(posedge MCLK) #1 chk({LAD_OE_N, LAD_O}, 5'h0f);
				@(posedge MCLK);
			end
		end
	endtask
	task t_reset;
		begin
			chk({REFRESH_N, DACK_N, TC, HOST_IRQ}, 25'h1fe0000);
			reg_rd(8'h00, 32'h983);
			reg_rd(8'h04, 32'h0);
			reg_rd(8'h0c, 32'h0);
		end
	endtask
	task t_io;
		begin
			lpc(4'h2, 16'h300, 8'h5a, 1, 0);
			chk(wdat, 8'h5a);
			lpc(4'h0, 16'h310, 0, 1, 8'h10);
			@(posedge MCLK) wide <= 1'b1;
			lpc(4'h0, 16'h301, 0, 1, 8'hfe);
			lpc(4'h2, 16'h302, 8'hc3, 1, 0);
			chk(wdat, 8'hc3);
			@(posedge MCLK) stall <= 5'h14;
			lpc(4'h0, 16'h310, 0, 1, 8'h10);
			reg_rd(8'h08, 32'h4);
			@(posedge MCLK) stall <= 5'h1f;
			lpc(4'h0, 16'h310, 0, 1, 8'h10);
			reg_rd(8'h08, 32'hc);
			@(posedge MCLK) stall <= 5'h00;
		end
	endtask
	task t_claim;
		begin
			lpc(4'h0, 16'hc90, 0, 1, 8'hff);
			lpc(4'h2, 16'hcbf, 8'h11, 1, 0);
			lpc(4'h0, 16'h3f8, 0, 0, 0);
			lpc(4'h0, 16'h2ff, 0, 0, 0);
			@(posedge MCLK) oc <= 1'b1;
			lpc(4'h0, 16'h300, 0, 0, 0);
			@(posedge MCLK) oc <= 1'b0;
			reg_wr(8'h00, 32'h901);
			lpc(4'h0, 16'h3f8, 0, 1, 8'hf8);
			lpc(4'h0, 16'h2f8, 0, 1, 8'hf8);
			lpc(4'h0, 16'h207, 0, 0, 0);
			lpc(4'h0, 16'h208, 0, 1, 8'h08);
		end
	endtask
	task t_mem;
		begin
			lpc(4'h4, 32'ha0000, 0, 1, 8'h00);
			lpc(4'h4, 32'hb7fff, 0, 1, 8'hff);
			lpc(4'h4, 32'hb8000, 0, 0, 0);
			lpc(4'h6, 32'h9ffff, 8'h11, 0, 0);
			lpc(4'h6, 32'hb0000, 8'h77, 1, 0);
			chk(wdat, 8'h77);
		end
	endtask
	task t_irq;
		begin
			@(posedge MCLK) irq <= 16'hffff;
			reg_wr(8'h04, 32'hffff);
			repeat (4) @(posedge MCLK);
			#1 chk(HOST_IRQ, 16'h9ef8);
			reg_rd(8'h04, 32'h9ef8);
			reg_wr(8'h04, 32'h8);
			repeat (4) @(posedge MCLK);
			#1 chk(HOST_IRQ, 16'h0008);
		end
	endtask
	initial
	begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end
	initial
	begin
		{rstn, rwr, rrd, oc, wide, ra, rwd, irq, stall} = 0;
		lfr_n = 1'b1;
		lad = 4'hf;
		failures = 0;
		checked = 0;
		repeat (3) @(posedge MCLK);
		rstn <= 1'b1;
		@(posedge MCLK) #1 t_reset;
		t_io;
		t_claim;
		t_mem;
		t_irq;
		end_of_test;
	end
endmodule // lib_bridge_tb_top
